// file: rail_cmd_defs.vh
// Constants for the voltage rail command logic
`ifndef RAIL_CMD_DEFS_VH
`define RAIL_CMD_DEFS_VH
// Command codes
`define CMD_FAST        4'h1
`define CMD_SLOW        4'h2
`define CMD_DECAY       4'h3
`define CMD_PSET        4'h4
`define CMD_VMAX        4'h5
// Power states
`define PS_FULL         8'h00
`define PS_LIGHT        8'h01
`define PS_VLIGHT       8'h02
// Rail addresses
`define RAIL_CORE       4'h0
`define RAIL_SA         4'h1
`define RAIL_MEM        4'h2
// Voltage codes
`define VID_OFF         8'h00
`define VID_MIN         8'h33
`define VID_MEM_135     8'hdd
`define VID_MEM_150     8'hfb
// Maximum voltage register
`define REG_VMAX        8'h30
// Acknowledge codes
`define ACK_OK          2'b00
`define ACK_REJECT      2'b11
`endif

// file: voltage_rail_command_logic.v
// Command issue logic for the serial voltage bus to the regulator
`timescale 1ns/1ns
// What this block does
// - Decay command only for downward voltage changes
// - Power states: 00 full, 01 light, 02 very light
// - Power state sent as one payload byte
// - Re-send low power state after upward change (code re-sends it only while low_current is set)
// - Each packet carries 4-bit rail address
// - Rails: 00 core, 01 agent, 02 memory
// - 8-bit voltage codes, 33h 0.5V, 5mV steps
// - Code 00 is off; never send 01-32 in fast, slow or decay commands (max voltage value is not checked)
// - Memory rail gets only fixed 1.35/1.5V code
// - Fast and slow commands carry target code
// - Program maximum voltage register 30h
`include "rail_cmd_defs.vh"
module voltage_rail_command_logic (
  // Clock and reset
  input  wire       clock,
  input  wire       rstn,
  input  wire       clk_en,
  // Request side
  input  wire       req_valid,
  output wire       req_ready,
  input  wire [3:0] req_kind,
  input  wire [3:0] req_rail,
  input  wire [7:0] req_value,
  input  wire       low_current,
  input  wire       mem_sel_150,
  output reg        req_error,
  // Packet side to serial framer
  output reg        pkt_valid,
  input  wire       pkt_ready,
  output reg  [3:0] pkt_cmd,
  output reg  [3:0] pkt_addr,
  output reg  [7:0] pkt_payload,
  input  wire       ack_valid,
  input  wire [1:0] ack_code,
  // Status
  output reg  [7:0] core_vid,
  output reg  [7:0] sa_vid,
  output reg  [7:0] mem_vid,
  output reg  [7:0] core_ps,
  output reg  [7:0] sa_ps,
  output reg  [7:0] ps_reject
);

  // ==========================================
  // States
  localparam ST_IDLE = 4'b0001;
  localparam ST_SEND = 4'b0010;
  localparam ST_WAIT = 4'b0100;
  localparam ST_RESEND = 4'b1000;

  // ==========================================
  // Registers
  reg [3:0] state_q;
  reg [7:0] last_ps_q;
  reg [3:0] rail_q;
  reg       raised_q;

  // ==========================================
  // Status selection by rail
  function [7:0] cur_vid;
    input [3:0] rail;
    input [7:0] c;
    input [7:0] s;
    input [7:0] m;
    begin
      case (rail)
        `RAIL_CORE: cur_vid = c;
        `RAIL_SA: cur_vid = s;
        default: cur_vid = m;
      endcase
    end
  endfunction

  function [7:0] rail_ps;
    input [3:0] rail;
    input [7:0] c;
    input [7:0] s;
    begin
      case (rail)
        `RAIL_CORE: rail_ps = c;
        `RAIL_SA: rail_ps = s;
        default: rail_ps = `PS_FULL;
      endcase
    end
  endfunction

  // ==========================================
  // Rail decode, one bit per rail
  function [2:0] rail_sel;
    input [3:0] rail;
    begin
      case (rail)
        `RAIL_CORE: rail_sel = 3'b001;
        `RAIL_SA: rail_sel = 3'b010;
        `RAIL_MEM: rail_sel = 3'b100;
        default: rail_sel = 3'b000;
      endcase
    end
  endfunction

  // ==========================================
  // Voltage code legality
  function code_legal;
    input [7:0] code;
    begin
      code_legal = (code == `VID_OFF) || (code >= `VID_MIN);
    end
  endfunction

  // ==========================================
  // Request checks
  wire [7:0] old_vid = cur_vid(req_rail, core_vid, sa_vid, mem_vid);
  wire rail_ok = |rail_sel(req_rail);
  wire is_vid = (req_kind == `CMD_FAST) || (req_kind == `CMD_SLOW)
                || (req_kind == `CMD_DECAY);
  wire is_vmax = (req_kind == `CMD_VMAX);
  wire vid_ok = code_legal(req_value);
  wire [7:0] mem_code = mem_sel_150 ? `VID_MEM_150 : `VID_MEM_135;
  wire mem_ok = (req_rail != `RAIL_MEM) || !is_vid || (req_value == mem_code);
  wire decay_ok = (req_kind != `CMD_DECAY) || (req_value < old_vid);
  wire ps_ok = (req_kind != `CMD_PSET) || (req_value == `PS_FULL)
               || (req_value == `PS_LIGHT) || (req_value == `PS_VLIGHT);
  wire kind_ok = is_vid || (req_kind == `CMD_PSET) || is_vmax;
  wire all_ok = rail_ok && kind_ok && (!is_vid || vid_ok) && mem_ok
                && decay_ok && ps_ok;
  wire raising = is_vid && (req_value > old_vid);

  // ==========================================
  // Acknowledge decode
  wire [2:0] hit = rail_sel(rail_q);
  wire ack_ok = ack_valid && (ack_code != `ACK_REJECT);
  wire ack_rej = ack_valid && (ack_code == `ACK_REJECT);

  // ==========================================
  // Handshake
  assign req_ready = (state_q == ST_IDLE);

  // ==========================================
  // Sequencer
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      pkt_valid <= 1'b0;
      pkt_cmd <= 4'h0;
      pkt_addr <= 4'h0;
      pkt_payload <= 8'h00;
      req_error <= 1'b0;
      core_vid <= `VID_OFF;
      sa_vid <= `VID_OFF;
      mem_vid <= `VID_OFF;
      core_ps <= `PS_FULL;
      sa_ps <= `PS_FULL;
      ps_reject <= 8'h00;
      last_ps_q <= `PS_FULL;
      rail_q <= 4'h0;
      raised_q <= 1'b0;
    end else if (clk_en) begin
      req_error <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (req_valid) begin
            if (!all_ok) begin
              req_error <= 1'b1;
            end else begin
              pkt_valid <= 1'b1;
              pkt_cmd <= req_kind;
              pkt_addr <= req_rail;
              pkt_payload <= req_value;
              rail_q <= req_rail;
              raised_q <= raising;
              last_ps_q <= rail_ps(req_rail, core_ps, sa_ps);
              state_q <= ST_SEND;
            end
          end
        end
        ST_SEND: begin
          if (pkt_ready) begin
            pkt_valid <= 1'b0;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ack_valid) begin
            state_q <= ST_IDLE;
          end
          if (ack_rej && pkt_cmd == `CMD_PSET) begin
            ps_reject <= pkt_payload;
          end
          if (ack_ok) begin
            if (pkt_cmd == `CMD_PSET) begin
              if (hit[0]) core_ps <= pkt_payload;
              if (hit[1]) sa_ps <= pkt_payload;
            end else if (pkt_cmd != `CMD_VMAX) begin
              if (hit[0]) core_vid <= pkt_payload;
              if (hit[1]) sa_vid <= pkt_payload;
              if (hit[2]) mem_vid <= pkt_payload;
              if (raised_q) begin
                if (hit[0]) core_ps <= `PS_FULL;
                if (hit[1]) sa_ps <= `PS_FULL;
                if (low_current && last_ps_q != `PS_FULL) begin
                  state_q <= ST_RESEND;
                end
              end
            end
          end
        end
        ST_RESEND: begin
          pkt_valid <= 1'b1;
          pkt_cmd <= `CMD_PSET;
          pkt_payload <= last_ps_q;
          raised_q <= 1'b0;
          state_q <= ST_SEND;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // voltage_rail_command_logic

// file: rail_checker.sv
// Assertions on the rail command ports
`timescale 1ns/1ns
`include "rail_cmd_defs.vh"
module rail_checker (
  // Control
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       clk_en,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic       req_error,
  input wire logic       low_current,
  // Packet
  input wire logic       pkt_valid,
  input wire logic       pkt_ready,
  input wire logic [3:0] pkt_cmd,
  input wire logic [3:0] pkt_addr,
  input wire logic [7:0] pkt_payload,
  input wire logic       ack_valid,
  input wire logic [1:0] ack_code,
  input wire logic [7:0] core_vid,
  input wire logic [7:0] core_ps
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire v = pkt_valid && pkt_cmd inside {`CMD_FAST, `CMD_SLOW, `CMD_DECAY};
  sequence s_up;
    pkt_valid && pkt_ready && !pkt_addr && pkt_cmd == `CMD_FAST && pkt_payload > core_vid
      && core_ps != `PS_FULL;
  endsequence
  sequence s_ack;
    ack_valid && ack_code != `ACK_REJECT && low_current;
  endsequence
  a_pkt_held: assert property (pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_payload))
    else $error("packet dropped");
  a_req_answer: assert property (clk_en && req_valid && req_ready |=> req_error != pkt_valid)
    else $error("no answer");
  a_busy_ready: assert property (pkt_valid |-> !req_ready) else $error("ready while busy");
  a_rail_addr: assert property (pkt_valid |-> pkt_addr <= `RAIL_MEM) else $error("bad rail");
  a_code_range: assert property (v |-> !pkt_payload || pkt_payload >= `VID_MIN)
    else $error("bad code");
  a_ps_code: assert property (pkt_valid && pkt_cmd == `CMD_PSET |-> pkt_payload <= `PS_VLIGHT)
    else $error("bad state");
  a_decay_down: assert property (v && pkt_cmd == `CMD_DECAY && !pkt_addr |-> pkt_payload < core_vid)
    else $error("decay upward");
  a_ps_resend: assert property (first_match(s_up ##[1:40] s_ack) |-> ##[1:3] pkt_cmd == `CMD_PSET)
    else $error("no resend");
endmodule // rail_checker
bind voltage_rail_command_logic rail_checker i_rail_checker (.clock, .rstn, .clk_en, .req_valid,
  .req_ready, .req_error, .low_current, .pkt_valid, .pkt_ready, .pkt_cmd, .pkt_addr,
  .pkt_payload, .ack_valid, .ack_code, .core_vid, .core_ps);

// file: reg_model.sv
// Behavioural regulator on the packet side
`timescale 1ns/1ns
module reg_model #(parameter logic [7:0] PS_TOP = 8'h01) (
  // Clock
  input  wire logic       clock,
  input  wire logic       slow,
  // Packet side
  input  wire logic       pkt_valid,
  output logic            pkt_ready,
  input  wire logic [3:0] pkt_cmd,
  input  wire logic [3:0] pkt_addr,
  input  wire logic [7:0] pkt_payload,
  output logic            ack_valid,
  output logic [1:0]      ack_code
);
  logic [7:0] vid [4], vmax, ps, d;
  logic [3:0] c, a;
  initial begin
    {pkt_ready, ack_valid, ack_code, ps, vmax} = {12'h000, 8'hff};
    vid = '{default: 8'h00};
    forever begin
      @(posedge clock);
      if (pkt_valid) begin
        repeat (slow * 3) @(posedge clock);
        #1 pkt_ready = 1;
        @(posedge clock) {c, a, d} = {pkt_cmd, pkt_addr, pkt_payload};
        #1 pkt_ready = 0;
        ack_code = 2'h0;
        if (c == 4'h5) vmax = d;
        else if (c == 4'h4 && d > PS_TOP) ack_code = 2'h3;
        else if (c == 4'h4) ps = d;
        else if (d > vmax) ack_code = 2'h3;
        else begin
          if (d > vid[a]) ps = 8'h00;
          vid[a] = d;
        end
        ack_valid = 1;
        @(posedge clock) #1 ack_valid = 0;
        ack_code = ~ack_code;
      end
    end
  end
endmodule // reg_model

// file: voltage_rail_command_logic_test.sv
// Self-checking bench for the rail command logic
`timescale 1ns/1ns
module voltage_rail_command_logic_test;
  logic        clock, rstn, clk_en, req_valid, req_ready, req_error, low_current, mem_sel_150;
  logic        pkt_valid, pkt_ready, ack_valid, slow, err;
  logic [1:0]  ack_code;
  logic [3:0]  req_kind, req_rail, pkt_cmd, pkt_addr;
  logic [7:0]  req_value, pkt_payload, core_vid, sa_vid, mem_vid, core_ps, sa_ps, ps_reject;
  int          n_fail, comparisons, w, n;
  wire  [47:0] st = {ps_reject, sa_ps, core_ps, mem_vid, sa_vid, core_vid};
  logic [31:0] rows [15] = '{32'h1080_0080, 32'h2133_0133, 32'h3040_0040, 32'h3040_1040,
    32'h1032_1040, 32'h1000_0000, 32'h1380_1000, 32'h12dd_02dd, 32'h12fb_12dd, 32'h4102_0502,
    32'h4003_1300, 32'h6000_1300, 32'h4000_0300, 32'h4001_0301, 32'h4101_0401};
  voltage_rail_command_logic i_voltage_rail_command_logic (.clock(clock), .rstn(rstn),
    .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind),
    .req_rail(req_rail), .req_value(req_value), .low_current(low_current),
    .mem_sel_150(mem_sel_150), .req_error(req_error), .pkt_valid(pkt_valid),
    .pkt_ready(pkt_ready), .pkt_cmd(pkt_cmd), .pkt_addr(pkt_addr), .pkt_payload(pkt_payload),
    .ack_valid(ack_valid), .ack_code(ack_code), .core_vid(core_vid), .sa_vid(sa_vid),
    .mem_vid(mem_vid), .core_ps(core_ps), .sa_ps(sa_ps), .ps_reject(ps_reject));
  reg_model i_reg_model (.clock(clock), .slow(slow), .pkt_valid(pkt_valid),
    .pkt_ready(pkt_ready), .pkt_cmd(pkt_cmd), .pkt_addr(pkt_addr), .pkt_payload(pkt_payload),
    .ack_valid(ack_valid), .ack_code(ack_code));
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  initial begin
    #40000 n_fail++;
    complete_run;
  end
  task complete_run;
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task req(input logic [3:0] k, r, input logic [7:0] v);
    {req_kind, req_rail, req_value, req_valid} = {k, r, v, 1'b1};
    @(posedge clock);
    for (w = 0; w < 99 && !(clk_en && req_ready); w++) @(posedge clock);
    if (w == 99) n_fail++;
    #1 req_valid = 0;
    err = req_error;
    for (w = 0, n = 0; w < 99 && n < 3; w++) @(posedge clock) #1 n = req_ready ? n + 1 : 0;
    if (n < 3) n_fail++;
  endtask
  initial begin
    {rstn, clk_en, req_valid, low_current, mem_sel_150, slow} = 6'b010000;
    {req_kind, req_rail, req_value} = 16'h0000;
    repeat (6) @(posedge clock);
    #1 rstn = 1;
    foreach (rows[i]) begin
      req(rows[i][31:28], rows[i][27:24], rows[i][23:16]);
      check({7'h0, err}, {7'h0, rows[i][12]});
      check(st[rows[i][11:8] * 8 +: 8], rows[i][7:0]);
    end
    {low_current, slow} = 2'b11;
    req(4'h1, 4'h0, 8'h90);
    check(core_ps, 8'h01);
    low_current = 0;
    req(4'h1, 4'h0, 8'ha0);
    check(core_ps, 8'h00);
    req(4'h5, 4'h0, 8'ha8);
    req(4'h1, 4'h0, 8'hb0);
    check(core_vid, 8'ha0);
    req(4'h5, 4'h0, 8'hff);
    {mem_sel_150, clk_en} = 2'b10;
    fork
      req(4'h1, 4'h2, 8'hfb);
      #40 clk_en = 1;
    join
    check(mem_vid, 8'hfb);
    rstn = 0;
    #20 check(core_vid, 8'h00);
    check(mem_vid, 8'h00);
    check({7'h0, pkt_valid}, 8'h00);
    @(posedge clock) #1 rstn = 1;
    req(4'h2, 4'h1, 8'h40);
    check({7'h0, err}, 8'h00);
    check(sa_vid, 8'h40);
    complete_run;
  end
endmodule // voltage_rail_command_logic_test
